// ===== nand_host_ctrl.sv
// host controller driving the NAND async pins from APB registers
// assumes APB master on the same clock and a pulled-up ready/busy line
`timescale 1ns/1ps
module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic CHIP_ENABLE_N_O,
  output logic CMD_LATCH_O,
  output logic ADDR_LATCH_O,
  output logic WRITE_STROBE_N_O,
  output logic READ_STROBE_N_O,
  output logic WRITE_PROTECT_N_O,
  input wire logic [7:0] IO_I,
  output logic [7:0] IO_O,
  output logic [7:0] IO_OE_O,
  input wire logic READY_BUSY_N_I
);
  typedef enum logic [5:0] {
    S_PWR = 6'h01,
    S_IDLE = 6'h02,
    S_CMD = 6'h04,
    S_ADR = 6'h08,
    S_RD = 6'h10,
    S_GAP = 6'h20
  } state_t;

  state_t state_r;
  logic [31:0] cnt_r;
  logic [7:0] op_r;
  logic [2:0] nadr_r;
  logic [2:0] ai_r;
  logic rd_r;
  logic [39:0] addr_r;
  logic [7:0] data_r;
  logic wpn_r;
  logic cen_r;
  logic reset_done_r;
  logic busy_cmd;
  logic wr_acc;
  logic strobe_lo;

  // opcodes a busy target still takes: status reads and reset
  function automatic logic busy_ok(input logic [7:0] op);
    logic ok;
    ok = (op == OP_STATUS) || (op == OP_STATUS_ENH) || (op == OP_RESET);
    return ok;
  endfunction

  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign PREADY_O = 1'b1;
  // a command can only be queued while idle; otherwise it errors
  // array, lock and otp opcodes are refused with an error while the target is busy
  assign busy_cmd = (state_r != S_IDLE) ||
                    (!READY_BUSY_N_I && PADDR_I == OFS_CMD &&
                     !busy_ok(PWDATA_I[7:0]));
  assign PSLVERR_O = PSEL_I && PENABLE_I &&
                     ((PWRITE_I && PADDR_I == OFS_CMD && busy_cmd) ||
                      (PADDR_I > OFS_DATA));
  assign strobe_lo = cnt_r < 32'(STROBE_CYC);

  always_comb begin
    unique case (PADDR_I)
      OFS_CTRL: PRDATA_O = {30'h0, cen_r, wpn_r};
      OFS_ADDR: PRDATA_O = addr_r[31:0];
      OFS_STAT: PRDATA_O = {28'h0, reset_done_r, READY_BUSY_N_I, state_r == S_IDLE,
                            state_r == S_PWR};
      OFS_DATA: PRDATA_O = {24'h0, data_r};
      default: PRDATA_O = 32'h0000_0000;
    endcase
  end

  // write protect held low until software lifts it after power-up
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wpn_r <= 1'b0;
      cen_r <= 1'b1;
      addr_r <= 40'h0;
    end else if (wr_acc) begin
      // change only while target ready and sequencer idle
      if (PADDR_I == OFS_CTRL && state_r == S_IDLE && READY_BUSY_N_I) begin
        wpn_r <= PWDATA_I[CTRL_WPN_BIT];
        cen_r <= PWDATA_I[CTRL_CEN_BIT];
      end
      if (PADDR_I == OFS_ADDR) addr_r <= {8'h0, PWDATA_I};
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= S_PWR;
      cnt_r <= 32'h0;
      op_r <= 8'h00;
      nadr_r <= 3'h0;
      ai_r <= 3'h0;
      rd_r <= 1'b0;
      data_r <= 8'h00;
      reset_done_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_PWR: begin
          // hold off until supply settled and line reads ready
          if (cnt_r >= 32'(PWRUP_CYCLES) && READY_BUSY_N_I) begin
            state_r <= S_IDLE;
            cnt_r <= 32'h0;
          end else cnt_r <= cnt_r + 32'h1;
        end
        S_IDLE: begin
          // cache, two-plane and lock sequences are left to software
          if (wr_acc && PADDR_I == OFS_CMD && !busy_cmd) begin
            // first command after power-up is forced to reset
            op_r <= reset_done_r ? PWDATA_I[7:0] : OP_RESET;
            nadr_r <= reset_done_r ? PWDATA_I[CMD_NADDR_LSB +: 3] : 3'h0;
            rd_r <= reset_done_r && PWDATA_I[CMD_RD_BIT];
            reset_done_r <= 1'b1;
            ai_r <= 3'h0;
            cnt_r <= 32'h0;
            state_r <= S_CMD;
          end else if (wr_acc && PADDR_I == OFS_CTRL && READY_BUSY_N_I &&
                       PWDATA_I[CTRL_WPN_BIT] != wpn_r) begin
            // pin moved: hold off the next command for the settle time
            cnt_r <= 32'h0;
            state_r <= S_GAP;
          end
        end
        S_CMD, S_ADR: begin
          if (cnt_r == 32'(2 * STROBE_CYC - 1)) begin
            cnt_r <= 32'h0;
            if (state_r == S_CMD && nadr_r != 3'h0) state_r <= S_ADR;
            else if (state_r == S_ADR && ai_r + 3'h1 < nadr_r) ai_r <= ai_r + 3'h1;
            else state_r <= rd_r ? S_RD : S_GAP;
          end else cnt_r <= cnt_r + 32'h1;
        end
        S_RD: begin
          if (cnt_r == 32'(STROBE_CYC - 1)) data_r <= IO_I;
          if (cnt_r == 32'(2 * STROBE_CYC - 1)) begin
            cnt_r <= 32'h0;
            state_r <= S_GAP;
          end else cnt_r <= cnt_r + 32'h1;
        end
        S_GAP: begin
          if (cnt_r == 32'(WW_CYC - 1)) begin
            cnt_r <= 32'h0;
            state_r <= S_IDLE;
          end else cnt_r <= cnt_r + 32'h1;
        end
        default: state_r <= S_PWR;
      endcase
    end
  end

  // pin drive from flops; strobe low in first half of each slot
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CHIP_ENABLE_N_O <= 1'b1;
      CMD_LATCH_O <= 1'b0;
      ADDR_LATCH_O <= 1'b0;
      WRITE_STROBE_N_O <= 1'b1;
      READ_STROBE_N_O <= 1'b1;
      IO_O <= 8'h00;
      IO_OE_O <= 8'h00;
      WRITE_PROTECT_N_O <= 1'b0;
    end else begin
      WRITE_PROTECT_N_O <= wpn_r;
      CHIP_ENABLE_N_O <= cen_r && (state_r == S_IDLE || state_r == S_PWR);
      CMD_LATCH_O <= state_r == S_CMD;
      ADDR_LATCH_O <= state_r == S_ADR;
      WRITE_STROBE_N_O <= !((state_r == S_CMD || state_r == S_ADR) && strobe_lo);
      READ_STROBE_N_O <= !(state_r == S_RD && strobe_lo);
      IO_OE_O <= (state_r == S_CMD || state_r == S_ADR) ? 8'hFF : 8'h00;
      IO_O <= (state_r == S_ADR) ? addr_r[ai_r * 8 +: 8] : op_r;
    end
  end

  cmd_strobe_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !WRITE_STROBE_N_O |->
      (CMD_LATCH_O ^ ADDR_LATCH_O) && READ_STROBE_N_O)
    else $error("write strobe without single latch");
  rd_latch_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !READ_STROBE_N_O |->
      !CMD_LATCH_O && !ADDR_LATCH_O && !CHIP_ENABLE_N_O)
    else $error("read strobe with latch high");
  pwr_wait_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_PWR && cnt_r < 32'(PWRUP_CYCLES) |=>
      state_r == S_PWR)
    else $error("left power-up wait early");
  rb_wait_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_PWR && !READY_BUSY_N_I |=>
      state_r == S_PWR)
    else $error("left power-up while line busy");
  first_reset_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(reset_done_r) |->
      op_r == OP_RESET)
    else $error("first command not reset");
  wp_stable_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $changed(wpn_r) |->
      $past(READY_BUSY_N_I) && $past(state_r) == S_IDLE)
    else $error("write protect moved while busy");
  wp_gap_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $changed(wpn_r) |->
      state_r == S_GAP && cnt_r == 32'h0)
    else $error("no settle gap after write protect");
  gap_len_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_GAP && cnt_r < 32'(WW_CYC - 1) |=>
      state_r == S_GAP)
    else $error("gap too short");
  wp_pin_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $changed(WRITE_PROTECT_N_O) |->
      !CMD_LATCH_O && !ADDR_LATCH_O)
    else $error("write protect moved inside a cycle");
  addr_count_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_ADR |->
      ai_r < nadr_r)
    else $error("address cycle overrun");
  wp_powerup_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_PWR |->
      !wpn_r)
    else $error("write protect high during power-up");
  // five samples low matches the strobe half slot
  wr_width_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(WRITE_STROBE_N_O) |->
      !WRITE_STROBE_N_O [*5] ##1 WRITE_STROBE_N_O)
    else $error("write strobe width wrong");
  rd_width_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(READ_STROBE_N_O) |->
      !READ_STROBE_N_O [*5] ##1 READ_STROBE_N_O)
    else $error("read strobe width wrong");
  ce_low_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !WRITE_STROBE_N_O |->
      !CHIP_ENABLE_N_O)
    else $error("write strobe with chip enable high");
  io_drive_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !WRITE_STROBE_N_O |->
      IO_OE_O == 8'hFF)
    else $error("bus not driven under write strobe");
  io_float_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !READ_STROBE_N_O |->
      IO_OE_O == 8'h00)
    else $error("bus driven under read strobe");
  busy_refuse_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_acc && PADDR_I == OFS_CMD && !READY_BUSY_N_I && !busy_ok(PWDATA_I[7:0]) |->
      PSLVERR_O)
    else $error("array command taken while busy");
  status_ok_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    wr_acc && PADDR_I == OFS_CMD && state_r == S_IDLE && busy_ok(PWDATA_I[7:0]) |->
      !PSLVERR_O)
    else $error("status command refused");
  idle_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_r == S_IDLE && $past(state_r) == S_IDLE |->
      WRITE_STROBE_N_O && READ_STROBE_N_O && !CMD_LATCH_O && !ADDR_LATCH_O)
    else $error("pins active while idle");
  pslv_map_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    PSEL_I && PENABLE_I && PADDR_I > OFS_DATA |->
      PSLVERR_O)
    else $error("unmapped access not flagged");
  cov_reset_c: cover property (@(posedge REF_CLK_I) $rose(reset_done_r));
  cov_addr_c: cover property (@(posedge REF_CLK_I) state_r == S_ADR ##1 state_r == S_GAP);
  cov_read_c: cover property (@(posedge REF_CLK_I) state_r == S_RD);
  cov_wp_c: cover property (@(posedge REF_CLK_I) $changed(wpn_r));
  cov_busy_c: cover property (@(posedge REF_CLK_I) state_r == S_CMD && !READY_BUSY_N_I);
endmodule

// ===== nand_host_pkg.sv
// constants for the host-side NAND command sequencer
// assumes a 200 MHz system clock and an APB software port
package nand_host_pkg;
  localparam int CLK_MHZ = 200;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  // ctrl fields
  localparam int CTRL_WPN_BIT = 0;
  localparam int CTRL_CEN_BIT = 1;
  // cmd fields: [7:0] opcode, [10:8] address cycles, [11] read one byte
  localparam int CMD_NADDR_LSB = 8;
  localparam int CMD_RD_BIT = 11;
  // opcodes
  localparam logic [7:0] OP_RESET = 8'hFF;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_STATUS_ENH = 8'h78;
  // timing
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRUP_US = 100;
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int WW_NS = 100;
  localparam int WW_CYC = (WW_NS * CLK_MHZ + 999) / 1000;
endpackage

// ===== nand_dev_model.sv
// behavioural one-die target: latches, status, busy timer
// assumes strobes held several clk cycles; rb line pulled up by tb
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int BUSY_CYC = 200
) (
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_pull_o
);
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] stat_r = 8'h60;
  logic [7:0] addr_r [$];
  int busy_r = 0;
  logic we_q = 1'b1, re_q = 1'b1, wp_q = 1'b0, smode_r = 1'b0;
  initial io_o = 8'h00;
  always @(posedge clk_i) begin
    if (busy_r > 0) begin
      busy_r = busy_r - 1;
      if (busy_r == 0) stat_r = wp_n_i ? 8'hE0 : 8'h60;
    end
    if (wp_q != wp_n_i && busy_r > 1) busy_r = 1;
    if (we_n_i && !we_q && !ce_n_i && re_n_i) begin
      if (cle_i && !ale_i && (busy_r == 0 || io_i inside {8'h70, 8'h78, 8'hFF})) begin
        cmd_r = io_i;
        smode_r = (io_i == 8'h70);
        if (io_i inside {8'hFF, 8'h10, 8'hD0, 8'h30}) busy_r = BUSY_CYC;
        if (io_i inside {8'h00, 8'h80, 8'h60}) addr_r.delete();
      end
      if (ale_i && !cle_i && busy_r == 0) addr_r.push_back(io_i);
    end
    // released bus toggles so a stale value never passes
    if (!re_n_i && re_q && !ce_n_i && !cle_i && !ale_i)
      io_o = smode_r ? (busy_r > 0 ? 8'h00 : {wp_n_i, stat_r[6:0]}) : 8'hA5;
    else if (re_n_i)
      io_o = ~io_o;
    we_q = we_n_i;
    re_q = re_n_i;
    wp_q = wp_n_i;
  end
  assign rb_pull_o = busy_r > 0;
endmodule

// ===== tb.sv
// self-checking bench for the host controller over APB
// assumes the device model and the controller share one clock
`timescale 1ns/1ps
module tb;
  import nand_host_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, io_i, io_o, io_oe;
  logic [31:0] pwdata, prdata, r, a;
  logic ce_n, cle, ale, we_n, re_n, wp_n, e, pull;
  int n_errors = 0, num_checks = 0, cyc = 0, n;
  nand_host_ctrl #(.PWRUP_CYCLES(50)) uut (.REF_CLK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CHIP_ENABLE_N_O(ce_n), .CMD_LATCH_O(cle),
    .ADDR_LATCH_O(ale), .WRITE_STROBE_N_O(we_n), .READ_STROBE_N_O(re_n),
    .WRITE_PROTECT_N_O(wp_n), .IO_I(io_i), .IO_O(io_o), .IO_OE_O(io_oe),
    .READY_BUSY_N_I(!pull));
  nand_dev_model dev (.clk_i(clk), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n),
    .io_i(io_oe == 8'hFF ? io_o : ~io_o), .io_o(io_i), .rb_pull_o(pull));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task complete_run;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task poll(input int b, input logic v);
    for (int i = 0; i < 2000; i++) begin
      apb(0, OFS_STAT, 0);
      if (r[b] === v) break;
    end
  endtask
  function automatic logic [31:0] rd_cmd(input logic [7:0] op);
    return 32'h800 | op;
  endfunction
  task status(input logic [7:0] exp);
    apb(1, OFS_CMD, rd_cmd(OP_STATUS));
    poll(1, 1);
    apb(0, OFS_DATA, 0);
    chk("status", r[7:0], exp);
  endtask
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    void'($urandom(32'h1803));
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("wp_n", wp_n, 0);
    poll(0, 0);
    poll(1, 1);
    apb(1, OFS_CMD, 32'h90);
    poll(1, 1);
    chk("first", dev.cmd_r, OP_RESET);
    chk("rb", r[2], 0);
    apb(1, OFS_CMD, 32'h80);
    chk("refuse", e, 1);
    apb(1, OFS_CMD, 32'h78);
    chk("enh_busy", e, 0);
    poll(1, 1);
    status(8'h00);
    apb(1, OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk("wp_busy", wp_n, 0);
    poll(2, 1);
    status(8'h60);
    apb(1, OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk("wp_set", wp_n, 1);
    poll(1, 1);
    for (int k = 0; k < 4; k++) begin
      a = $urandom;
      n = (k == 0) ? 4 : $urandom_range(1, 4);
      apb(1, OFS_ADDR, a);
      apb(1, OFS_CMD, (n << CMD_NADDR_LSB) | 32'h00);
      poll(1, 1);
      chk("n_addr", dev.addr_r.size(), n);
      for (int i = 0; i < n; i++) chk("addr", dev.addr_r[i], a[8*i+:8]);
    end
    status(8'hE0);
    apb(0, 8'h14, 0);
    chk("unmapped", {r[30:0], e}, 1);
    complete_run;
  end
endmodule
